// *** apo_consts.vh ***
// constants for the attribute pixel output stage
`ifndef APO_CONSTS_VH
`define APO_CONSTS_VH
// i/o port selects on io_addr
`define APO_PORT_ATTR_WR 2'h0
`define APO_PORT_ATTR_RD 2'h1
`define APO_PORT_STAT1 2'h2
// attribute register indices
`define APO_IDX_MODE 5'h10
`define APO_IDX_BORDER 5'h11
`define APO_IDX_PLANE 5'h12
`define APO_IDX_SHIFT 5'h13
`define APO_IDX_UPPER 5'h14
`define APO_IDX_PAL_TOP 5'h0f
// index register fields
`define APO_INDEX_MASK 8'h3f
`define APO_INDEX_SRC_BIT 5
// writable bit masks, reserved bits read zero
`define APO_PAL_MASK 8'h3f
`define APO_MODE_MASK 8'hef
`define APO_BORDER_MASK 8'hff
`define APO_PLANE_MASK 8'h3f
`define APO_SHIFT_MASK 8'h0f
`define APO_UPPER_MASK 8'h0f
// mode control bits
`define APO_MODE_GFX 0
`define APO_MODE_MONO 1
`define APO_MODE_LGE 2
`define APO_MODE_BLINK 3
`define APO_MODE_PANCMP 5
`define APO_MODE_HALF 6
`define APO_MODE_HISEL 7
// reset values
`define APO_RST_REG 8'h00
`define APO_RST_PAL 6'h00
// pan limits
`define APO_PAN_NONE9 4'h8
// pixel word fields
`define APO_W_WIDTH 12
`define APO_W_ATTR_HI 7
`define APO_W_DOT 8
`define APO_W_NINTH 9
`define APO_W_LGC 10
`define APO_W_ACTIVE 11
// fifo depth
`define APO_FIFO_DEPTH 8
`define APO_FIFO_AW 3
`endif

// *** apo_top.v ***
// attribute pixel output stage with its input fifo
`timescale 1ns/1ps
`include "apo_consts.vh"

module apo_fifo #(
	parameter WIDTH = `APO_W_WIDTH,
	parameter DEPTH = `APO_FIFO_DEPTH,
	parameter AW = `APO_FIFO_AW
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	reg [AW:0] cnt_nxt;
	reg ready_r;
	wire push;
	wire pop;
	assign push = in_valid & ready_r;
	assign pop = out_ready & (cnt_r != {(AW+1){1'b0}});
	assign in_ready = ready_r;
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem[rp_r];
	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + {{AW{1'b0}}, 1'b1};
		else if (pop & ~push)
			cnt_nxt = cnt_r - {{AW{1'b0}}, 1'b1};
	end
	always @(posedge clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			ready_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ready_r <= (cnt_nxt != DEPTH[AW:0]);
			if (push)
				wp_r <= (wp_r == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}} : wp_r + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rp_r <= (rp_r == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}} : rp_r + {{(AW-1){1'b0}}, 1'b1};
		end
	end
endmodule // apo_fifo

// Operation
// RL1: mode bit 7 clear sends palette bits 5:4 to outputs 5:4, set sends upper select bits 1:0 there; the code ignores bit 7 in 256-colour graphics.
// RL2: pixel width clear gives a pixel clock at the dot rate, set gives half the dot rate for 256 colours.
// RL3: with panning compatibility set, a line compare stops panning and the crtc pan bits until vertical sync.
// RL4: blink select clear makes attribute bit 7 background intensity, set makes it the blink attribute.
// RL5: the ninth dot of line-graphics codes is background when disabled and copies the eighth dot when enabled.
// RL6: outside the active display the eight-bit border colour drives all pixel outputs.
// RL7: software should program the border colour to zero for a monochrome display.
// RL8: each colour plane with a clear enable bit forces its index bit to zero before the palette.
// RL9: the status pair select picks which two pixel outputs show in input status 1 bits 5 and 4.
// RL10: in nine-dot modes a pan of 0 to 7 shifts left by value plus one and 8 gives no shift.
// RL11: in eight-dot modes a pan of 0 to 7 shifts left by that many pixels.
// RL12: in 256-colour mode pans 0, 2, 4, 6 shift left by 0, 1, 2, 3 pixels.
// RL13: upper select bits 3:2 drive outputs 7:6 except in 256-colour graphics.
// RL14: attribute registers are written at the write port and read at the read port using the current index.
// RL15: a flip-flop alternates write-port writes between index and data; status reads reset it, read-port reads do not.
// RL16: palette source clear blanks palette and video outputs for host access; set resumes translation.
// RL17: reserved attribute bits ignore writes and read as zero.
module apo_top (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// host i/o port
	input wire [1:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output wire [7:0] io_rdata_r,
	output wire io_rvalid_r,
	// pixel stream in
	input wire pix_valid,
	output wire pix_ready,
	input wire [`APO_W_WIDTH-1:0] pix_data,
	input wire pix_line_start,
	// timing context
	input wire char9_mode,
	input wire blink_phase,
	input wire line_compare,
	input wire vsync,
	// crtc side
	output wire crtc_pan_disable_r,
	// dac side
	output wire pixel_clk_r,
	output wire pixel_out_bit0,
	output wire pixel_out_bit1,
	output wire pixel_out_bit2,
	output wire pixel_out_bit3,
	output wire pixel_out_bit4,
	output wire pixel_out_bit5,
	output wire pixel_out_bit6,
	output wire pixel_out_bit7
);
	reg rst_meta_r;
	reg rst_n_r;
	reg [5:0] index_r;
	reg flip_r;
	reg [5:0] pal_r [0:15];
	reg [7:0] mode_r;
	reg [7:0] border_r;
	reg [7:0] plane_r;
	reg [7:0] shift_r;
	reg [7:0] upper_r;
	reg [7:0] rdata_r;
	reg rvalid_r;
	reg [7:0] pix_r;
	reg [1:0] phase_r;
	reg pclk_r;
	reg pan_off_r;
	reg [3:0] skip_r;
	reg last_dot_r;
	reg [7:0] rd_nxt;
	reg [3:0] pan_amt;
	reg [3:0] cur_skip;
	reg [3:0] idx;
	reg [7:0] pix_nxt;
	reg dot_eff;
	reg fg_hide;
	reg [3:0] bg;
	reg [1:0] stat;
	integer i;
	wire [`APO_W_WIDTH:0] f_in;
	wire [`APO_W_WIDTH:0] f_out;
	wire f_valid;
	wire tick;
	wire pop;
	wire half;
	wire gfx;
	wire [3:0] pen;
	wire [5:0] pal_lo;
	wire [5:0] pal_hi;
	wire [5:0] pal_t;
	wire [7:0] attr;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// line start rides in the fifo so the pan restart stays aligned with its pixel
	assign f_in = {pix_line_start, pix_data};
	apo_fifo #(
		.WIDTH(`APO_W_WIDTH + 1),
		.DEPTH(`APO_FIFO_DEPTH),
		.AW(`APO_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n_r),
		.in_valid(pix_valid),
		.in_ready(pix_ready),
		.in_data(f_in),
		.out_valid(f_valid),
		.out_ready(tick),
		.out_data(f_out)
	);

	// host register port
	always @* begin
		rd_nxt = 8'h00;
		case (io_addr)
			`APO_PORT_ATTR_WR: rd_nxt = {2'b00, index_r};
			`APO_PORT_ATTR_RD: begin
				if (index_r[4:0] <= `APO_IDX_PAL_TOP)
					rd_nxt = {2'b00, pal_r[index_r[3:0]]};
				else if (index_r[4:0] == `APO_IDX_MODE)
					rd_nxt = mode_r;
				else if (index_r[4:0] == `APO_IDX_BORDER)
					rd_nxt = border_r;
				else if (index_r[4:0] == `APO_IDX_PLANE)
					rd_nxt = plane_r;
				else if (index_r[4:0] == `APO_IDX_SHIFT)
					rd_nxt = shift_r;
				else if (index_r[4:0] == `APO_IDX_UPPER)
					rd_nxt = upper_r; // RL14
			end
			`APO_PORT_STAT1: rd_nxt = {2'b00, stat, 4'h0}; // RL9
			default: rd_nxt = 8'h00;
		endcase
	end

	always @* begin
		case (plane_r[5:4])
			2'h0: stat = {pix_r[2], pix_r[0]};
			2'h1: stat = {pix_r[5], pix_r[4]};
			2'h2: stat = {pix_r[3], pix_r[1]};
			default: stat = {pix_r[7], pix_r[6]}; // RL9
		endcase
	end

	always @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			index_r <= 6'h00;
			flip_r <= 1'b0;
			mode_r <= `APO_RST_REG;
			border_r <= `APO_RST_REG;
			plane_r <= `APO_RST_REG;
			shift_r <= `APO_RST_REG;
			upper_r <= `APO_RST_REG;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			for (i = 0; i < 16; i = i + 1)
				pal_r[i] <= `APO_RST_PAL;
		end else begin
			rvalid_r <= io_rd;
			if (io_rd)
				rdata_r <= rd_nxt;
			if (io_rd && io_addr == `APO_PORT_STAT1)
				flip_r <= 1'b0; // RL15
			else if (io_wr && io_addr == `APO_PORT_ATTR_WR) begin
				flip_r <= ~flip_r; // RL15
				if (!flip_r)
					index_r <= io_wdata[5:0]; // RL17
				else if (index_r[4:0] <= `APO_IDX_PAL_TOP)
					pal_r[index_r[3:0]] <= io_wdata[5:0]; // RL14
				else if (index_r[4:0] == `APO_IDX_MODE)
					mode_r <= io_wdata & `APO_MODE_MASK; // RL17
				else if (index_r[4:0] == `APO_IDX_BORDER)
					border_r <= io_wdata & `APO_BORDER_MASK;
				else if (index_r[4:0] == `APO_IDX_PLANE)
					plane_r <= io_wdata & `APO_PLANE_MASK; // RL17
				else if (index_r[4:0] == `APO_IDX_SHIFT)
					shift_r <= io_wdata & `APO_SHIFT_MASK; // RL17
				else if (index_r[4:0] == `APO_IDX_UPPER)
					upper_r <= io_wdata & `APO_UPPER_MASK; // RL17
			end
		end
	end
	assign io_rdata_r = rdata_r;
	assign io_rvalid_r = rvalid_r;

	// dot clock is clk/2; half mode stretches each pixel over four clk cycles
	assign half = mode_r[`APO_MODE_HALF];
	assign gfx = mode_r[`APO_MODE_GFX];
	assign tick = half ? (phase_r == 2'h3) : phase_r[0]; // RL2
	assign pop = tick & f_valid;

	always @* begin
		if (mode_r[`APO_MODE_HALF])
			pan_amt = {2'b00, shift_r[2:1]}; // RL12
		else if (char9_mode)
			pan_amt = (shift_r[3:0] < `APO_PAN_NONE9) ? shift_r[3:0] + 4'h1 : 4'h0; // RL10
		else
			pan_amt = {1'b0, shift_r[2:0]}; // RL11
		if (pan_off_r)
			pan_amt = 4'h0; // RL3
		cur_skip = f_out[`APO_W_WIDTH] ? pan_amt : skip_r;
	end

	assign attr = f_out[`APO_W_ATTR_HI:0];
	assign pen = plane_r[3:0];
	assign pal_lo = pal_r[attr[3:0] & pen]; // RL8
	assign pal_hi = pal_r[attr[7:4] & pen]; // RL8

	always @* begin
		if (f_out[`APO_W_NINTH])
			dot_eff = (mode_r[`APO_MODE_LGE] & f_out[`APO_W_LGC]) ? last_dot_r : 1'b0; // RL5
		else
			dot_eff = f_out[`APO_W_DOT];
		fg_hide = mode_r[`APO_MODE_BLINK] & attr[7] & blink_phase; // RL4
		bg = mode_r[`APO_MODE_BLINK] ? {1'b0, attr[6:4]} : attr[7:4]; // RL4
		if (gfx)
			idx = attr[3:0];
		else
			idx = (dot_eff & ~fg_hide) ? attr[3:0] : bg;
	end
	assign pal_t = pal_r[idx & pen]; // RL8

	always @* begin
		if (!index_r[`APO_INDEX_SRC_BIT])
			pix_nxt = 8'h00; // RL16
		else if (!f_out[`APO_W_ACTIVE])
			pix_nxt = border_r; // RL6
		else if (half & gfx)
			pix_nxt = {pal_hi[3:0], pal_lo[3:0]};
		else
			pix_nxt = {upper_r[3:2], mode_r[`APO_MODE_HISEL] ? upper_r[1:0] : pal_t[5:4], pal_t[3:0]}; // RL1 RL13
	end

	always @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			phase_r <= 2'h0;
			pclk_r <= 1'b0;
			pan_off_r <= 1'b0;
			skip_r <= 4'h0;
			last_dot_r <= 1'b0;
			pix_r <= 8'h00;
		end else begin
			phase_r <= tick ? 2'h0 : phase_r + 2'h1;
			pclk_r <= half ? (phase_r == 2'h0 || phase_r == 2'h3) : ~phase_r[0]; // RL2
			// set wins over the vsync clear
			if (line_compare & mode_r[`APO_MODE_PANCMP])
				pan_off_r <= 1'b1; // RL3
			else if (vsync)
				pan_off_r <= 1'b0; // RL3
			if (pop) begin
				if (!f_out[`APO_W_NINTH])
					last_dot_r <= f_out[`APO_W_DOT];
				// skipped pixels are consumed without output, so the source must send the extras
				if (cur_skip != 4'h0 && f_out[`APO_W_ACTIVE]) begin
					skip_r <= cur_skip - 4'h1; // RL10 RL11 RL12
				end else begin
					skip_r <= cur_skip;
					pix_r <= pix_nxt;
				end
			end
		end
	end

	assign crtc_pan_disable_r = pan_off_r;
	assign pixel_clk_r = pclk_r;
	assign {pixel_out_bit7, pixel_out_bit6, pixel_out_bit5, pixel_out_bit4,
		pixel_out_bit3, pixel_out_bit2, pixel_out_bit1, pixel_out_bit0} = pix_r;
endmodule // apo_top

// *** apo_props.sv ***
// port assertions for the attribute pixel output stage
`timescale 1ns/1ps
module apo_props (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// host port
	input wire [1:0] io_addr,
	input wire io_rd,
	input wire [7:0] io_rdata_r,
	input wire io_rvalid_r,
	// timing and outputs
	input wire line_compare,
	input wire vsync,
	input wire crtc_pan_disable_r,
	input wire pixel_clk_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	property p_rd_ans; io_rd |=> io_rvalid_r; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_only; !io_rd |=> !io_rvalid_r; endproperty
	a_rd_only: assert property (p_rd_only) else $error("answer without read");
	property p_rd_hold; !io_rvalid_r |-> $stable(io_rdata_r); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_stat_rsv; io_rd && io_addr == 2'h2 |=> (io_rdata_r & 8'hcf) == 8'h00; endproperty
	a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
	property p_no_port; io_rd && io_addr == 2'h3 |=> io_rdata_r == 8'h00; endproperty
	a_no_port: assert property (p_no_port) else $error("unused port nonzero");
	property p_pan_clr; vsync && !line_compare |=> !crtc_pan_disable_r; endproperty
	a_pan_clr: assert property (p_pan_clr) else $error("pan off past vsync");
	property p_pan_keep; crtc_pan_disable_r && !vsync |=> crtc_pan_disable_r; endproperty
	a_pan_keep: assert property (p_pan_keep) else $error("pan off dropped early");
	property p_pan_set; $rose(crtc_pan_disable_r) |-> $past(line_compare); endproperty
	a_pan_set: assert property (p_pan_set) else $error("pan off without compare");
	property p_pclk; pixel_clk_r |-> ##[1:2] !pixel_clk_r; endproperty
	a_pclk: assert property (p_pclk) else $error("pixel clock high too long");
	c_read: cover property (io_rvalid_r);
	c_pan: cover property ($rose(crtc_pan_disable_r));
	c_half: cover property (pixel_clk_r [*2]);
endmodule // apo_props
bind apo_top apo_props u_props (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_rd(io_rd),
	.io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r), .line_compare(line_compare), .vsync(vsync),
	.crtc_pan_disable_r(crtc_pan_disable_r), .pixel_clk_r(pixel_clk_r));

// *** apo_dac_model.sv ***
// video dac model: latches the pixel byte on each pixel clock rise
`timescale 1ns/1ps
module apo_dac_model (
	// dac pins
	input wire pclk,
	input wire [7:0] pix
);
	reg [7:0] last_r;
	integer n_edges;
	initial n_edges = 0;
	always @(posedge pclk) begin
		last_r <= pix;
		n_edges <= n_edges + 1;
	end
endmodule // apo_dac_model

// *** attribute_pixel_output_stage_bench.sv ***
// self-checking bench for the attribute pixel output stage
`timescale 1ns/1ps
`include "apo_consts.vh"
module attribute_pixel_output_stage_bench;
	reg clk, reset_n, io_wr, io_rd, pix_valid, line_compare, vsync;
	reg pix_line_start, char9_mode, blink_phase;
	reg [1:0] io_addr;
	reg [7:0] io_wdata;
	reg [11:0] pix_data;
	wire [7:0] io_rdata_r, px;
	wire io_rvalid_r, pix_ready, crtc_pan_disable_r, pixel_clk_r;
	integer n_fail, n_tests;
	apo_top dut (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_rvalid_r(io_rvalid_r), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .pix_data(pix_data), .pix_line_start(pix_line_start), .char9_mode(char9_mode),
		.blink_phase(blink_phase), .line_compare(line_compare), .vsync(vsync),
		.crtc_pan_disable_r(crtc_pan_disable_r), .pixel_clk_r(pixel_clk_r), .pixel_out_bit0(px[0]),
		.pixel_out_bit1(px[1]), .pixel_out_bit2(px[2]), .pixel_out_bit3(px[3]), .pixel_out_bit4(px[4]),
		.pixel_out_bit5(px[5]), .pixel_out_bit6(px[6]), .pixel_out_bit7(px[7]));
	apo_dac_model dac (.pclk(pixel_clk_r), .pix(px));
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [1:0] a, input [7:0] d);
		begin
			@(posedge clk) #1;
			io_addr = a;
			io_wdata = d;
			io_wr = 1'b1;
			@(posedge clk) #1;
			io_wr = 1'b0;
		end
	endtask
	task rd(input [1:0] a, output [7:0] d);
		begin
			@(posedge clk) #1;
			io_addr = a;
			io_rd = 1'b1;
			@(posedge clk) #1;
			io_rd = 1'b0;
			d = io_rdata_r;
		end
	endtask
	task setr(input [7:0] idx, input [7:0] val);
		begin
			wr(2'h0, idx);
			wr(2'h0, val);
		end
	endtask
	// pixel outputs are registered and hold, so a fixed settle past two ticks suffices
	task push(input [11:0] w);
		begin
			@(posedge clk) #1;
			pix_data = w;
			pix_valid = 1'b1;
			while (pix_ready !== 1'b1) @(posedge clk) #1;
			@(posedge clk) #1;
			pix_valid = 1'b0;
			pix_line_start = 1'b0;
			repeat (12) @(posedge clk);
			#1;
		end
	endtask
	task strobe(input sel);
		begin
			@(posedge clk) #1;
			if (sel) line_compare = 1'b1;
			else vsync = 1'b1;
			@(posedge clk) #1;
			line_compare = 1'b0;
			vsync = 1'b0;
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	function [7:0] msk(input [2:0] i);
		case (i)
			3'h0: msk = `APO_MODE_MASK;
			3'h1: msk = `APO_BORDER_MASK;
			3'h2: msk = `APO_PLANE_MASK;
			3'h3: msk = `APO_SHIFT_MASK;
			default: msk = `APO_UPPER_MASK;
		endcase
	endfunction
	task t_regs;
		reg [7:0] d;
		integer i;
		begin
			rd(2'h2, d);
			for (i = 0; i < 5; i = i + 1) begin
				setr(8'h30 | {5'h0, i[2:0]}, 8'hff);
				rd(2'h1, d);
				chk(d, msk(i[2:0]));
				rd(2'h0, d);
				chk(d, 8'h30 | {5'h0, i[2:0]});
			end
			setr(8'h35, 8'hff);
			rd(2'h1, d);
			chk(d, 8'h00);
			rd(2'h3, d);
			chk(d, 8'h00);
		end
	endtask
	task t_pix;
		reg [7:0] d;
		begin
			rd(2'h2, d);
			setr(8'h00, 8'h00);
			setr(8'h01, 8'h2d);
			setr(8'h33, 8'h00);
			setr(8'h31, 8'ha5);
			setr(8'h34, 8'h0d);
			setr(8'h30, 8'h01);
			setr(8'h32, 8'h1f);
			push(12'h000);
			chk(px, 8'ha5);
			chk(dac.last_r, 8'ha5);
			push(12'h801);
			chk(px, 8'hed);
			rd(2'h2, d);
			chk(d, 8'h20);
			setr(8'h30, 8'h81);
			push(12'h801);
			chk(px, 8'hdd);
			setr(8'h32, 8'h1e);
			push(12'h801);
			chk(px, 8'hd0);
			wr(2'h0, 8'h12);
			push(12'h801);
			chk(px, 8'h00);
		end
	endtask
	task t_clk;
		reg [7:0] d;
		integer e;
		begin
			rd(2'h2, d);
			setr(8'h32, 8'h0f);
			setr(8'h30, 8'h01);
			repeat (4) @(posedge clk);
			e = dac.n_edges;
			repeat (16) @(posedge clk);
			chk(dac.n_edges - e, 8'h08);
			setr(8'h30, 8'h41);
			push(12'h810);
			chk(px, 8'hd0);
			e = dac.n_edges;
			repeat (16) @(posedge clk);
			chk(dac.n_edges - e, 8'h04);
		end
	endtask
	task t_pan;
		reg [7:0] d;
		begin
			rd(2'h2, d);
			setr(8'h30, 8'h21);
			strobe(1'b1);
			chk(crtc_pan_disable_r, 8'h01);
			strobe(1'b0);
			chk(crtc_pan_disable_r, 8'h00);
			setr(8'h30, 8'h01);
			strobe(1'b1);
			chk(crtc_pan_disable_r, 8'h00);
		end
	endtask
	// the line start word and those after it are eaten by the pan count
	task t_shift;
		reg [7:0] d;
		begin
			rd(2'h2, d);
			setr(8'h30, 8'h01);
			setr(8'h33, 8'h03);
			push(12'h800);
			chk(px, 8'hc0);
			pix_line_start = 1'b1;
			push(12'h801);
			chk(px, 8'hc0);
			push(12'h801);
			chk(px, 8'hc0);
			push(12'h801);
			chk(px, 8'hc0);
			push(12'h801);
			chk(px, 8'hed);
			setr(8'h30, 8'h21);
			strobe(1'b1);
			push(12'h800);
			chk(px, 8'hc0);
			pix_line_start = 1'b1;
			push(12'h801);
			chk(px, 8'hed);
			strobe(1'b0);
			char9_mode = 1'b1;
			setr(8'h30, 8'h01);
			setr(8'h33, 8'h00);
			push(12'h800);
			chk(px, 8'hc0);
			pix_line_start = 1'b1;
			push(12'h801);
			chk(px, 8'hc0);
			push(12'h801);
			chk(px, 8'hed);
			setr(8'h33, 8'h08);
			push(12'h800);
			chk(px, 8'hc0);
			pix_line_start = 1'b1;
			push(12'h801);
			chk(px, 8'hed);
			char9_mode = 1'b0;
			setr(8'h30, 8'h41);
			setr(8'h33, 8'h04);
			push(12'h800);
			chk(px, 8'h00);
			pix_line_start = 1'b1;
			push(12'h810);
			chk(px, 8'h00);
			push(12'h810);
			chk(px, 8'h00);
			push(12'h810);
			chk(px, 8'hd0);
		end
	endtask
	// half rate drains one word per four clocks, so a held valid fills the fifo
	task t_fill;
		integer k;
		reg lo;
		begin
			lo = 1'b0;
			@(posedge clk) #1;
			pix_data = 12'h000;
			pix_valid = 1'b1;
			for (k = 0; k < 16; k = k + 1) begin
				@(posedge clk) #1;
				if (pix_ready === 1'b0) lo = 1'b1;
			end
			pix_valid = 1'b0;
			chk({7'h00, lo}, 8'h01);
			repeat (48) @(posedge clk);
			#1;
			chk({7'h00, pix_ready}, 8'h01);
			chk(px, 8'ha5);
		end
	endtask
	task t_text;
		reg [7:0] d;
		begin
			rd(2'h2, d);
			setr(8'h31, 8'h00);
			setr(8'h30, 8'h0e);
			push(12'h000);
			chk(px, 8'h00);
			blink_phase = 1'b1;
			push(12'h990);
			chk(px, 8'hed);
			blink_phase = 1'b0;
			push(12'h990);
			chk(px, 8'hc0);
			push(12'he90);
			chk(px, 8'hc0);
			setr(8'h30, 8'h0a);
			push(12'he90);
			chk(px, 8'hed);
			setr(8'h30, 8'h06);
			push(12'h890);
			chk(px, 8'hc0);
		end
	endtask
	task print_verdict;
		begin
			$display("tests %0d failures %0d", n_tests, n_fail);
			if (n_fail == 0 && n_tests > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		n_fail = 0;
		n_tests = 0;
		{reset_n, io_wr, io_rd, pix_valid, line_compare, vsync} = 6'h00;
		{pix_line_start, char9_mode, blink_phase} = 3'h0;
		io_addr = 2'h0;
		io_wdata = 8'h00;
		pix_data = 12'h000;
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_pix;
		t_clk;
		t_pan;
		t_shift;
		t_fill;
		t_text;
		print_verdict;
	end
	initial begin
		#40000;
		n_fail = n_fail + 1;
		print_verdict;
	end
endmodule // attribute_pixel_output_stage_bench
